// ---- logic/acs_pkg.sv ----
// Constants for the conversion sequencer: map, fields, resets, states.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package acs_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam int          ADDR_W = 5;
  localparam logic [4:0]  A_SC1  = 5'h00;
  localparam logic [4:0]  A_SC2  = 5'h04;
  localparam logic [4:0]  A_RESH = 5'h08;
  localparam logic [4:0]  A_RESL = 5'h0c;
  localparam logic [4:0]  A_CVH  = 5'h10;
  localparam logic [4:0]  A_CVL  = 5'h14;
  localparam logic [4:0]  A_CFG  = 5'h18;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SC1_DONE = 7;
  localparam int SC1_IEN  = 6;
  localparam int SC1_CONT = 5;
  localparam int SC2_ACT  = 7;
  localparam int SC2_TRG  = 6;
  localparam int SC2_CFE  = 5;
  localparam int SC2_CGE  = 4;
  localparam int CFG_MODE = 2;
  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [4:0] CH_OFF    = 5'h1f;
  localparam logic [4:0] CH_RST    = 5'h1f;
  localparam logic [1:0] CLK_BUS   = 2'h0;
  localparam logic [1:0] CLK_HALF  = 2'h1;
  localparam logic [1:0] CLK_ALT   = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;
  localparam logic [1:0] MODE_8    = 2'h0;
  localparam logic [1:0] MODE_12   = 2'h1;
  localparam logic [1:0] MODE_10   = 2'h2;
  localparam logic [3:0] CFG_RST   = 4'h0;
  localparam int         RES_W     = 12;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM  = 3'b010,
    ST_CONV = 3'b100
  } acs_state_t;
endpackage

// ---- logic/acs_sync.sv ----
// Three-stage input synchroniser with agreement filter and rise pulse.
// Assumes inputs are asynchronous to mclk.
module acs_sync #(
  parameter int W = 3
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff;
  logic [W-1:0] nxt_lvl, nxt_rise;

  // ---------------------------------------------------------------
  // Filter: only the second and third stages are compared
  // ---------------------------------------------------------------
  always_comb begin
    nxt_lvl  = lvl_ff;
    nxt_rise = '0;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_lvl[i] = s3_ff[i];
      end
      nxt_rise[i] = nxt_lvl[i] & ~lvl_ff[i];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_ff   <= '0;
      s2_ff   <= '0;
      s3_ff   <= '0;
      lvl_ff  <= '0;
      rise_ff <= '0;
    end else begin
      s1_ff   <= din;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      lvl_ff  <= nxt_lvl;
      rise_ff <= nxt_rise;
    end
  end

  assign level = lvl_ff;
  assign rise  = rise_ff;
endmodule // acs_sync

// ---- logic/acs_sar.sv ----
// Successive approximation register: one bit decided per tick.
// Assumes cmp_in is the analog comparator, valid one tick after code.
module acs_sar #(
  parameter int BITS = 12
) (
  input  wire logic            mclk,
  input  wire logic            nrst,
  input  wire logic            start,
  input  wire logic            abort,
  input  wire logic            tick,
  input  wire logic            cmp_in,
  output logic      [BITS-1:0] code,
  output logic                 busy,
  output logic                 done
);
  localparam int BW = $clog2(BITS);
  localparam logic [BW-1:0] TOP = BW'(BITS - 1);

  logic [BITS-1:0] code_ff, nxt_code;
  logic [BW-1:0]   bit_ff, nxt_bit;
  logic            busy_ff, nxt_busy, done_ff, nxt_done;

  always_comb begin
    nxt_code = code_ff;
    nxt_bit  = bit_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    // A restart beats an abort in the same cycle
    if (start) begin
      nxt_code      = '0;
      nxt_code[TOP] = 1'b1;
      nxt_bit       = TOP;
      nxt_busy      = 1'b1;
    end else if (abort) begin
      nxt_busy = 1'b0;
    end else if (busy_ff && tick) begin
      nxt_code[bit_ff] = cmp_in;
      if (bit_ff == '0) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end else begin
        nxt_code[bit_ff - 1'b1] = 1'b1;
        nxt_bit = bit_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      code_ff <= '0;
      bit_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      code_ff <= nxt_code;
      bit_ff  <= nxt_bit;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign code = code_ff;
  assign busy = busy_ff;
  assign done = done_ff;
endmodule // acs_sar

// ---- logic/acs_top.sv ----
// Conversion sequencer: registers, trigger, clock select, flags.
// Assumes an Avalon-MM master on mclk and an analog SAR comparator.
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.

module acs_top (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        hw_conv_trigger,
  input  wire logic        local_async_clock,
  input  wire logic        alternate_clock,
  input  wire logic        cmp_in,
  output logic      [11:0] sar_code,
  output logic      [4:0]  channel_out,
  output logic             conv_power,
  output logic             conv_irq
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic        wait_ff, nxt_wait;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        ien_ff, nxt_ien, cont_ff, nxt_cont;
  logic [4:0]  ch_ff, nxt_ch;
  logic        done_ff, nxt_done;
  logic        trg_ff, nxt_trg, cfe_ff, nxt_cfe, cge_ff, nxt_cge;
  logic [11:0] cv_ff, nxt_cv, res_ff, nxt_res;
  logic [3:0]  cfg_ff, nxt_cfg;
  logic        irq_ff, nxt_irq, pwr_ff, nxt_pwr, half_ff;
  acs_pkg::acs_state_t state_ff, nxt_state;

  logic        acc, wr, rd, wr_sc1, start, cmp_ok, tick;
  logic [2:0]  s_lvl, s_rise;
  logic [11:0] raw, fmt, cvm;
  logic [1:0]  mode;
  logic        sar_busy, sar_done;

  // ---------------------------------------------------------------
  // Input synchronisers and SAR engine
  // ---------------------------------------------------------------
  acs_sync #(.W(3)) u_sync (
    .mclk  (mclk),
    .nrst  (nrst),
    .din   ({alternate_clock, local_async_clock, hw_conv_trigger}),
    .level (s_lvl),
    .rise  (s_rise)
  );

  acs_sar #(.BITS(acs_pkg::RES_W)) u_sar (
    .mclk   (mclk),
    .nrst   (nrst),
    .start  (start),
    .abort  (wr_sc1),
    .tick   (tick),
    .cmp_in (cmp_in),
    .code   (raw),
    .busy   (sar_busy),
    .done   (sar_done)
  );

  // ---------------------------------------------------------------
  // Conversion clock select
  // ---------------------------------------------------------------
  // External clocks are sampled, so they must run below mclk / 4
  always_comb begin
    case (cfg_ff[1:0])
      acs_pkg::CLK_BUS:  tick = 1'b1;
      acs_pkg::CLK_HALF: tick = half_ff;
      acs_pkg::CLK_ALT:  tick = s_rise[2];
      default:           tick = s_rise[1];
    endcase
  end

  // ---------------------------------------------------------------
  // Result format and compare
  // ---------------------------------------------------------------
  always_comb begin
    mode = cfg_ff[acs_pkg::CFG_MODE +: 2];
    case (mode)
      acs_pkg::MODE_12: begin
        fmt = raw;
        cvm = cv_ff;
      end
      acs_pkg::MODE_10: begin
        fmt = {2'h0, raw[11:2]};
        cvm = {2'h0, cv_ff[9:0]};
      end
      default: begin
        fmt = {4'h0, raw[11:4]};
        cvm = {4'h0, cv_ff[7:0]};
      end
    endcase
    cmp_ok = !cfe_ff || (cge_ff ? (fmt >= cvm) : (fmt < cvm));
  end

  // ---------------------------------------------------------------
  // Bus slave and registers
  // ---------------------------------------------------------------
  always_comb begin
    acc      = (avs_read || avs_write) && wait_ff;
    wr       = acc && avs_write;
    rd       = acc && avs_read && !avs_write;
    wr_sc1   = wr && (avs_address == acs_pkg::A_SC1);
    nxt_wait = !acc;
    nxt_rdata = rdata_ff;
    nxt_ien  = ien_ff;
    nxt_cont = cont_ff;
    nxt_ch   = ch_ff;
    nxt_trg  = trg_ff;
    nxt_cfe  = cfe_ff;
    nxt_cge  = cge_ff;
    nxt_cv   = cv_ff;
    nxt_cfg  = cfg_ff;
    nxt_res  = res_ff;
    nxt_done = done_ff;
    if (rd) begin
      nxt_rdata = 32'h0;
      if (avs_address == acs_pkg::A_SC1) begin
        nxt_rdata[7:0] = {done_ff, ien_ff, cont_ff, ch_ff};
      end else if (avs_address == acs_pkg::A_SC2) begin
        nxt_rdata[acs_pkg::SC2_ACT] = (state_ff == acs_pkg::ST_CONV);
        nxt_rdata[acs_pkg::SC2_TRG] = trg_ff;
        nxt_rdata[acs_pkg::SC2_CFE] = cfe_ff;
        nxt_rdata[acs_pkg::SC2_CGE] = cge_ff;
      end else if (avs_address == acs_pkg::A_RESH) begin
        nxt_rdata[3:0] = res_ff[11:8];
      end else if (avs_address == acs_pkg::A_RESL) begin
        nxt_rdata[7:0] = res_ff[7:0];
        nxt_done = 1'b0;
      end else if (avs_address == acs_pkg::A_CVH) begin
        nxt_rdata[3:0] = cv_ff[11:8];
      end else if (avs_address == acs_pkg::A_CVL) begin
        nxt_rdata[7:0] = cv_ff[7:0];
      end else if (avs_address == acs_pkg::A_CFG) begin
        nxt_rdata[3:0] = cfg_ff;
      end
    end
    if (wr_sc1) begin
      nxt_ien  = avs_writedata[acs_pkg::SC1_IEN];
      nxt_cont = avs_writedata[acs_pkg::SC1_CONT];
      nxt_ch   = avs_writedata[4:0];
      nxt_done = 1'b0;
    end else if (wr && avs_address == acs_pkg::A_SC2) begin
      nxt_trg = avs_writedata[acs_pkg::SC2_TRG];
      nxt_cfe = avs_writedata[acs_pkg::SC2_CFE];
      nxt_cge = avs_writedata[acs_pkg::SC2_CGE];
    end else if (wr && avs_address == acs_pkg::A_CVH) begin
      nxt_cv[11:8] = avs_writedata[3:0];
    end else if (wr && avs_address == acs_pkg::A_CVL) begin
      nxt_cv[7:0] = avs_writedata[7:0];
    end else if (wr && avs_address == acs_pkg::A_CFG) begin
      nxt_cfg = avs_writedata[3:0];
    end
    // A finishing conversion wins over a clear in the same cycle
    if (sar_done && cmp_ok) begin
      nxt_done = 1'b1;
      nxt_res  = fmt;
    end
    nxt_irq = nxt_done && nxt_ien;
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    start     = 1'b0;
    if (wr_sc1) begin
      if (avs_writedata[4:0] == acs_pkg::CH_OFF) begin
        nxt_state = acs_pkg::ST_IDLE;
      end else if (trg_ff) begin
        nxt_state = acs_pkg::ST_ARM;
      end else begin
        start     = 1'b1;
        nxt_state = acs_pkg::ST_CONV;
      end
    end else begin
      case (state_ff)
        acs_pkg::ST_ARM: begin
          // Trigger is never gated by low-power state
          if (!trg_ff) begin
            nxt_state = acs_pkg::ST_IDLE;
          end else if (s_rise[0]) begin
            start     = 1'b1;
            nxt_state = acs_pkg::ST_CONV;
          end
        end
        acs_pkg::ST_CONV: begin
          if (sar_done) begin
            if (cont_ff) begin
              start = 1'b1;
            end else if (trg_ff) begin
              nxt_state = acs_pkg::ST_ARM;
            end else begin
              nxt_state = acs_pkg::ST_IDLE;
            end
          end
        end
        default: nxt_state = acs_pkg::ST_IDLE;
      endcase
    end
    nxt_pwr = (nxt_state == acs_pkg::ST_CONV);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0;
      ien_ff   <= 1'b0;
      cont_ff  <= 1'b0;
      ch_ff    <= acs_pkg::CH_RST;
      done_ff  <= 1'b0;
      trg_ff   <= 1'b0;
      cfe_ff   <= 1'b0;
      cge_ff   <= 1'b0;
      cv_ff    <= 12'h0;
      cfg_ff   <= acs_pkg::CFG_RST;
      res_ff   <= 12'h0;
      irq_ff   <= 1'b0;
      pwr_ff   <= 1'b0;
      half_ff  <= 1'b0;
      state_ff <= acs_pkg::ST_IDLE;
    end else begin
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
      ien_ff   <= nxt_ien;
      cont_ff  <= nxt_cont;
      ch_ff    <= nxt_ch;
      done_ff  <= nxt_done;
      trg_ff   <= nxt_trg;
      cfe_ff   <= nxt_cfe;
      cge_ff   <= nxt_cge;
      cv_ff    <= nxt_cv;
      cfg_ff   <= nxt_cfg;
      res_ff   <= nxt_res;
      irq_ff   <= nxt_irq;
      pwr_ff   <= nxt_pwr;
      half_ff  <= !half_ff;
      state_ff <= nxt_state;
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign sar_code        = raw;
  assign channel_out     = ch_ff;
  assign conv_power      = pwr_ff;
  assign conv_irq        = irq_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_bus_answer: assert property ((avs_read || avs_write) && wait_ff
    |=> !wait_ff ##1 wait_ff)
    else $error("bus answer not one cycle");
  a_sc1_restart: assert property (wr_sc1 && !trg_ff
    && avs_writedata[4:0] != acs_pkg::CH_OFF
    |=> state_ff == acs_pkg::ST_CONV && sar_busy)
    else $error("control write did not restart");
  a_off_idle: assert property (wr_sc1
    && avs_writedata[4:0] == acs_pkg::CH_OFF
    |=> state_ff == acs_pkg::ST_IDLE && !pwr_ff)
    else $error("channel off did not idle");
  a_flag_clear: assert property (wr_sc1 && !sar_done
    |=> !done_ff && !irq_ff)
    else $error("flag not cleared by write");
  a_flag_set: assert property (sar_done && !cfe_ff
    |=> done_ff)
    else $error("flag not set on done");
  a_cmp_block: assert property (sar_done && !cmp_ok && !done_ff
    |=> !done_ff && res_ff == $past(res_ff))
    else $error("failed compare set flag");
  a_irq_rise: assert property ($rose(done_ff) && ien_ff
    |-> irq_ff)
    else $error("interrupt missing");
  // A write or trigger right after done may legally restart, so one cycle
  a_single_idle: assert property (sar_done && !cont_ff && !wr_sc1
    |=> !pwr_ff && !sar_busy && state_ff != acs_pkg::ST_CONV)
    else $error("no return to idle");
  a_cont_again: assert property (sar_done && cont_ff && !wr_sc1
    |=> sar_busy && pwr_ff)
    else $error("continuous did not restart");
  a_hw_start: assert property (state_ff == acs_pkg::ST_ARM && trg_ff
    && s_rise[0] && !wr_sc1 |=> sar_busy)
    else $error("trigger did not start");
  a_one_start: assert property (state_ff == acs_pkg::ST_ARM
    && !s_rise[0] && !wr_sc1 |=> !sar_busy)
    else $error("start without trigger");

  c_single: cover property (wr_sc1 ##[1:40] sar_done);
  c_hw: cover property (state_ff == acs_pkg::ST_ARM ##1 s_rise[0]);
  c_cont: cover property (sar_done && cont_ff);
  c_cmp: cover property (sar_done && cfe_ff && cmp_ok);
endmodule // acs_top

// ---- testbench/acs_far_model.sv ----
// Far side model: analog comparator, trigger source, two clock sources.
// Assumes the bench sets the analog level and pulses fire for a trigger.
module acs_far_model (
  input  wire logic        mclk,
  input  wire logic [11:0] sar_code,
  input  wire logic [11:0] analog_level,
  input  wire logic        fire,
  output logic             cmp_in,
  output logic             hw_conv_trigger,
  output logic             local_async_clock,
  output logic             alternate_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Clock sources, free running, unrelated to mclk
  // ---------------------------------------------------------------
  initial begin
    local_async_clock = 1'b0;
    alternate_clock   = 1'b0;
    hw_conv_trigger   = 1'b0;
  end
  always #18.5 local_async_clock = ~local_async_clock;
  always #26.5 alternate_clock = ~alternate_clock;
  // ---------------------------------------------------------------
  // Comparator and trigger pulse
  // ---------------------------------------------------------------
  assign cmp_in = (analog_level >= sar_code);
  // Pulse held 4 cycles so the 2-stage agreement filter surely agrees
  always @(posedge mclk) begin
    if (fire) begin
      hw_conv_trigger <= 1'b1;
      repeat (4) @(posedge mclk);
      hw_conv_trigger <= 1'b0;
    end
  end
endmodule // acs_far_model

// ---- testbench/acs_top_tb_top.sv ----
// Self-checking bench for the conversion sequencer over Avalon-MM.
// Assumes acs_pkg is compiled first and the far model beside it.
module acs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [4:0]  ch;
    logic [1:0]  clk;
    logic [1:0]  mode;
    logic [11:0] ana;
    logic [11:0] res;
  } acs_row_t;
  logic        mclk, nrst, avs_read, avs_write, avs_waitrequest;
  logic        cmp_in, conv_power, conv_irq, fire, pw_q;
  logic        hw_conv_trigger, local_async_clock, alternate_clock;
  logic [4:0]  avs_address, channel_out;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [11:0] sar_code, ana;
  int          err_total, checked, cyc, conv_starts, n0;
  acs_row_t    rows [6] = '{
    '{5'h00, 2'h0, 2'h1, 12'hfff, 12'hfff},
    '{5'h0f, 2'h1, 2'h1, 12'h000, 12'h000},
    '{5'h10, 2'h2, 2'h2, 12'h5a7, 12'h169},
    '{5'h1b, 2'h3, 2'h0, 12'ha53, 12'h0a5},
    '{5'h1e, 2'h0, 2'h1, 12'h3c6, 12'h3c6},
    '{5'h1c, 2'h0, 2'h0, 12'h123, 12'h012}};
  acs_top DUT (
    .mclk(mclk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hw_conv_trigger(hw_conv_trigger),
    .local_async_clock(local_async_clock),
    .alternate_clock(alternate_clock), .cmp_in(cmp_in),
    .sar_code(sar_code), .channel_out(channel_out),
    .conv_power(conv_power), .conv_irq(conv_irq));
  acs_far_model far (
    .mclk(mclk), .sar_code(sar_code), .analog_level(ana), .fire(fire),
    .cmp_in(cmp_in), .hw_conv_trigger(hw_conv_trigger),
    .local_async_clock(local_async_clock),
    .alternate_clock(alternate_clock));
  // ---------------------------------------------------------------
  // Clock, timeout, start counter
  // ---------------------------------------------------------------
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      $display("wrong value at %0t: timeout", $time);
      tally_and_finish();
    end
    if (conv_power === 1'b1 && pw_q === 1'b0) conv_starts++;
    pw_q = conv_power;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic bus_rd(input logic [4:0] a, output logic [31:0] v);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    v = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      bus_rd(acs_pkg::A_SC1, d);
      n++;
    end while (d[7] !== 1'b1 && n < 300);
    chk(d[7], 1, "done flag not set");
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (conv_power !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    chk(n < 20, 1, "power never rose");
    n = 0;
    while (conv_power !== 1'b0 && n < 500) begin
      @(posedge mclk);
      n++;
    end
    chk(conv_power, 0, "power never fell");
  endtask
  task automatic chk_result(input logic [11:0] e);
    bus_rd(acs_pkg::A_RESH, d);
    chk(d, {28'h0, e[11:8]}, "result high");
    bus_rd(acs_pkg::A_RESL, d);
    chk(d, {24'h0, e[7:0]}, "result low");
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    fire = 1'b0;
    ana = 12'h000;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    chk(channel_out, 5'h1f, "channel after reset");
    chk(conv_power, 0, "power after reset");
    bus_rd(acs_pkg::A_SC1, d);
    chk(d, 32'h1f, "control one reset");
    bus_rd(acs_pkg::A_SC2, d);
    chk(d, 32'h0, "control two reset");
    bus_rd(acs_pkg::A_CFG, d);
    chk(d, 32'h0, "config reset");
    bus_rd(5'h1c, d);
    chk(d, 32'h0, "unmapped read");
    foreach (rows[i]) begin
      ana <= rows[i].ana;
      bus_wr(acs_pkg::A_CFG, {28'h0, rows[i].mode, rows[i].clk});
      n0 = conv_starts;
      bus_wr(acs_pkg::A_SC1, {27'h0, rows[i].ch});
      wait_done();
      chk(channel_out, rows[i].ch, "channel select");
      chk(conv_power, 0, "power after single");
      chk(conv_starts - n0, 1, "single conversion count");
      bus_rd(acs_pkg::A_SC2, d);
      chk(d[7], 0, "active after finish");
      chk_result(rows[i].res);
      bus_rd(acs_pkg::A_SC1, d);
      chk(d[7], 0, "flag after low read");
    end
    // Abort and restart: result must follow the second level only
    bus_wr(acs_pkg::A_CFG, 32'h4);
    ana <= 12'h111;
    bus_wr(acs_pkg::A_SC1, 32'h05);
    bus_rd(acs_pkg::A_SC2, d);
    chk(d[7], 1, "active mid conversion");
    ana <= 12'heee;
    bus_wr(acs_pkg::A_SC1, 32'h05);
    wait_done();
    chk_result(12'heee);
    // Interrupt, then power off clears it without a new conversion
    bus_wr(acs_pkg::A_SC1, 32'h45);
    wait_done();
    chk(conv_irq, 1, "interrupt raised");
    n0 = conv_starts;
    bus_wr(acs_pkg::A_SC1, 32'h5f);
    bus_rd(acs_pkg::A_SC1, d);
    chk(d[7], 0, "flag after control write");
    chk(conv_irq, 0, "interrupt cleared");
    repeat (40) @(posedge mclk);
    chk(conv_starts - n0, 0, "no conversion when off");
    // Compare: less-than holds, then ge fails
    bus_wr(acs_pkg::A_CVH, 32'h8);
    bus_wr(acs_pkg::A_CVL, 32'h0);
    ana <= 12'h100;
    bus_wr(acs_pkg::A_SC2, 32'h20);
    bus_wr(acs_pkg::A_SC1, 32'h02);
    wait_idle();
    bus_rd(acs_pkg::A_SC1, d);
    chk(d[7], 1, "less-than compare true");
    bus_wr(acs_pkg::A_SC2, 32'h30);
    bus_wr(acs_pkg::A_SC1, 32'h02);
    wait_idle();
    bus_rd(acs_pkg::A_SC1, d);
    chk(d[7], 0, "ge compare false");
    // Hardware trigger: armed, idle until the pulse, one start per pulse
    ana <= 12'h2d4;
    bus_wr(acs_pkg::A_SC2, 32'h40);
    bus_wr(acs_pkg::A_SC1, 32'h04);
    repeat (30) @(posedge mclk);
    chk(conv_power, 0, "no start without trigger");
    n0 = conv_starts;
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    wait_idle();
    repeat (40) @(posedge mclk);
    chk(conv_starts - n0, 1, "one start per pulse");
    wait_done();
    chk_result(12'h2d4);
    // Continuous after one trigger: flag keeps coming back
    bus_wr(acs_pkg::A_SC1, 32'h24);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    wait_done();
    chk_result(12'h2d4);
    wait_done();
    bus_wr(acs_pkg::A_SC1, 32'h3f);
    repeat (10) @(posedge mclk);
    n0 = conv_starts;
    chk(conv_power, 0, "continuous stopped");
    repeat (100) @(posedge mclk);
    chk(conv_starts - n0, 0, "no extra conversion");
    // Reset in mid-conversion: outputs back to idle, nothing restarts
    bus_wr(acs_pkg::A_SC2, 32'h0);
    bus_wr(acs_pkg::A_SC1, 32'h65);
    wait_done();
    chk(conv_irq, 1, "interrupt before reset");
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    chk(channel_out, 5'h1f, "channel after mid reset");
    chk(conv_power, 0, "power after mid reset");
    chk(conv_irq, 0, "interrupt after mid reset");
    n0 = conv_starts;
    bus_rd(acs_pkg::A_SC1, d);
    chk(d, 32'h1f, "control one after mid reset");
    repeat (40) @(posedge mclk);
    chk(conv_starts - n0, 0, "no start after mid reset");
    tally_and_finish();
  end
endmodule // acs_top_tb_top
